// *** verilog/ivt_pkg.sv ***
// constants, types and source numbering for the variable vector table
package ivt_pkg;
	localparam int IVT_ADDR_W = 20;
	localparam int IVT_NUM_W = 6;
	localparam int IVT_NSRC = 24;
	localparam int IVT_NLINE = 32;
	localparam int IVT_ENTRY_BYTES = 4;
	localparam int IVT_ENTRY_SHIFT = 2;
	localparam int IVT_OFF_W = IVT_NUM_W + IVT_ENTRY_SHIFT;
	localparam logic [IVT_ADDR_W-1:0] IVT_BASE_RST = 20'h00000;
	localparam logic [IVT_NUM_W-1:0] IVT_NUM_BREAK = 6'h00;
	localparam logic [IVT_NUM_W-1:0] IVT_NUM_SW_LO = 6'h20;
	localparam logic [1:0] IVT_LAST_BYTE = 2'h3;
	localparam logic [31:0] IVT_RESERVED = 32'h800000E0;

	// peripheral request lines, lowest field is bit 0
	typedef struct packed {
		logic external_request_pin_one;
		logic external_request_pin_zero;
		logic [2:0] timer_b;
		logic [4:0] timer_a;
		logic vsync_edge;
		logic slicer;
		logic uart0_rx;
		logic uart0_tx;
		logic uart2_rx;
		logic uart2_tx;
		logic adc_done;
		logic i2c_first;
		logic dma1;
		logic dma0;
		logic bus_collision;
		logic i2c_second;
		logic display_done_second;
		logic display_done_first;
	} ivt_src_s;

	// number of each source, indexed by bit position in ivt_src_s
	localparam logic [4:0] IVT_SRC_NUM [IVT_NSRC] = '{
		5'h04, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E,
		5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14,
		5'h15, 5'h16, 5'h17, 5'h18, 5'h19,
		5'h1A, 5'h1B, 5'h1C,
		5'h1D, 5'h1E
	};

	typedef struct packed {
		logic [IVT_ADDR_W-1:0] entry_addr;
		logic [IVT_ADDR_W-1:0] handler;
		logic [IVT_NUM_W-1:0] num;
		logic force_isp;
		logic nonmaskable;
	} ivt_vec_s;

	typedef enum logic [2:0] {
		IVT_ST_IDLE = 3'h1,
		IVT_ST_FETCH = 3'h2,
		IVT_ST_DONE = 3'h4
	} ivt_state_e;
endpackage

// *** verilog/ivt_src_map.sv ***
// maps peripheral request lines onto interrupt numbers 0 to 31
`timescale 1ns/1ps
`default_nettype none
module ivt_src_map
	import ivt_pkg::*;
(
	// requests
	input wire ivt_src_s srcs,
	// request lines by number
	output logic [IVT_NLINE-1:0] lines
);
	logic [IVT_NSRC-1:0] src_v;

	assign src_v = srcs;

	genvar n;
	generate
		for (n = 0; n < IVT_NLINE; n = n + 1)
		begin : g_line
			always_comb
			begin
				lines[n] = 1'b0;
				for (int i = 0; i < IVT_NSRC; i++)
				begin
					if (IVT_SRC_NUM[i] == 5'(n) && !IVT_RESERVED[n])
						lines[n] = lines[n] | src_v[i];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// *** verilog/ivt_entry_pack.sv ***
// gathers the four entry bytes into a handler address
`timescale 1ns/1ps
`default_nettype none
module ivt_entry_pack
	import ivt_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// byte in
	input wire logic clear,
	input wire logic load,
	input wire logic [1:0] idx,
	input wire logic [7:0] data,
	// assembled entry
	output logic [IVT_ADDR_W-1:0] handler
);
	logic [31:0] word_q;
	logic [31:0] word_d;

	always_comb
	begin
		word_d = word_q;
		if (clear)
			word_d = 32'h00000000;
		else if (load)
			word_d[{idx, 3'h0} +: 8] = data;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			word_q <= 32'h00000000;
		else
			word_q <= word_d;
	end

	assign handler = word_q[IVT_ADDR_W-1:0];
endmodule
`default_nettype wire

// *** verilog/ivt_vector.sv ***
// variable vector table: entry address, fetch and request numbering
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - each entry is four bytes at 4n
// - fetch address is base plus entry offset
// - lowest byte holds least significant part
// - numbers 0 and 32-63 ignore enable flag
// - display completions use numbers 4 and 8
// - numbers 5, 6, 7, 31 stay unused
// - serial sources on numbers 9 to 18
// - dma 11, 12; conversion done 14
// - slicer 19, vertical sync 20
// - timer a 21-25, timer b 26-28
// - external pins use numbers 29 and 30
// - peripheral and instruction share entries 0-31
// - numbers below 32 force interrupt stack pointer
module ivt_vector
	import ivt_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// vector base load from core
	input wire logic base_wr,
	input wire logic [IVT_ADDR_W-1:0] base_data,
	// core flags and peripheral requests
	input wire logic irq_enable,
	input wire ivt_src_s srcs,
	// acceptance from the core sequencer
	input wire logic take_valid,
	input wire logic take_sw,
	input wire logic [IVT_NUM_W-1:0] take_num,
	// vector byte fetch
	output logic mem_req,
	output logic [IVT_ADDR_W-1:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	// pending request to the core
	output logic pend_valid,
	output logic [IVT_NUM_W-1:0] pend_num,
	// result to the core
	output logic busy,
	output logic vec_valid,
	output ivt_vec_s vec,
	output logic [IVT_ADDR_W-1:0] vector_base_register
);
	logic [IVT_NLINE-1:0] lines;
	logic [IVT_ADDR_W-1:0] handler;
	logic [IVT_ADDR_W-1:0] entry_addr;

	ivt_state_e state_q;
	ivt_state_e state_d;
	logic [IVT_ADDR_W-1:0] base_q;
	logic [IVT_ADDR_W-1:0] base_d;
	logic [1:0] idx_q;
	logic [1:0] idx_d;
	logic mem_req_q;
	logic mem_req_d;
	logic [IVT_ADDR_W-1:0] mem_addr_q;
	logic [IVT_ADDR_W-1:0] mem_addr_d;
	logic busy_q;
	logic busy_d;
	logic vec_valid_q;
	logic vec_valid_d;
	ivt_vec_s vec_q;
	ivt_vec_s vec_d;
	logic pend_valid_q;
	logic pend_valid_d;
	logic [IVT_NUM_W-1:0] pend_num_q;
	logic [IVT_NUM_W-1:0] pend_num_d;
	logic pack_clear;
	logic pack_load;

	ivt_src_map u_map
	(
		.srcs(srcs),
		.lines(lines)
	);

	ivt_entry_pack u_pack
	(
		.sys_clk(sys_clk),
		.rstn(rstn),
		.clear(pack_clear),
		.load(pack_load),
		.idx(idx_q),
		.data(mem_rdata),
		.handler(handler)
	);

	// entry address, same table for instruction and peripheral
	assign entry_addr = base_q + IVT_ADDR_W'({take_num, IVT_ENTRY_SHIFT'(0)});

	// vector base register
	always_comb
	begin
		base_d = base_q;
		if (base_wr)
			base_d = base_data;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			base_q <= IVT_BASE_RST;
		else
			base_q <= base_d;
	end

	// lowest pending maskable number, gated by enable flag
	always_comb
	begin
		pend_valid_d = 1'b0;
		pend_num_d = pend_num_q;
		for (int n = IVT_NLINE - 1; n > 0; n--)
		begin
			if (lines[n] && irq_enable)
			begin
				pend_valid_d = 1'b1;
				pend_num_d = IVT_NUM_W'(n);
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			pend_valid_q <= 1'b0;
			pend_num_q <= '0;
		end
		else
		begin
			pend_valid_q <= pend_valid_d;
			pend_num_q <= pend_num_d;
		end
	end

	// fetch sequencer
	always_comb
	begin
		state_d = state_q;
		idx_d = idx_q;
		mem_req_d = mem_req_q;
		mem_addr_d = mem_addr_q;
		busy_d = busy_q;
		vec_valid_d = 1'b0;
		vec_d = vec_q;
		pack_clear = 1'b0;
		pack_load = 1'b0;
		case (state_q)
			IVT_ST_IDLE:
			begin
				if (take_valid)
				begin
					state_d = IVT_ST_FETCH;
					idx_d = 2'h0;
					pack_clear = 1'b1;
					mem_req_d = 1'b1;
					mem_addr_d = entry_addr;
					busy_d = 1'b1;
					vec_d.entry_addr = entry_addr;
					vec_d.num = take_num;
					vec_d.force_isp = (take_num < IVT_NUM_SW_LO);
					// break and instruction-only numbers bypass the flag
					vec_d.nonmaskable = take_sw || (take_num == IVT_NUM_BREAK) ||
						(take_num >= IVT_NUM_SW_LO);
				end
			end
			IVT_ST_FETCH:
			begin
				if (mem_ack)
				begin
					pack_load = 1'b1;
					if (idx_q == IVT_LAST_BYTE)
					begin
						state_d = IVT_ST_DONE;
						mem_req_d = 1'b0;
					end
					else
					begin
						idx_d = idx_q + 2'h1;
						mem_addr_d = mem_addr_q + IVT_ADDR_W'(1);
					end
				end
			end
			IVT_ST_DONE:
			begin
				state_d = IVT_ST_IDLE;
				vec_valid_d = 1'b1;
				vec_d.handler = handler;
				busy_d = 1'b0;
			end
			default:
			begin
				state_d = IVT_ST_IDLE;
				mem_req_d = 1'b0;
				busy_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			state_q <= IVT_ST_IDLE;
			idx_q <= 2'h0;
			mem_req_q <= 1'b0;
			mem_addr_q <= '0;
			busy_q <= 1'b0;
			vec_valid_q <= 1'b0;
			vec_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			idx_q <= idx_d;
			mem_req_q <= mem_req_d;
			mem_addr_q <= mem_addr_d;
			busy_q <= busy_d;
			vec_valid_q <= vec_valid_d;
			vec_q <= vec_d;
		end
	end

	assign mem_req = mem_req_q;
	assign mem_addr = mem_addr_q;
	assign busy = busy_q;
	assign vec_valid = vec_valid_q;
	assign vec = vec_q;
	assign pend_valid = pend_valid_q;
	assign pend_num = pend_num_q;
	assign vector_base_register = base_q;
endmodule
`default_nettype wire

// *** test/ivt_vector_sva.sv ***
// assertions on the vector table ports
`timescale 1ns/1ps
`default_nettype none
module ivt_vector_chk
	import ivt_pkg::*;
(
	// watched
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic irq_enable,
	input wire logic take_valid,
	input wire logic [IVT_NUM_W-1:0] take_num,
	input wire logic mem_req,
	input wire logic [IVT_ADDR_W-1:0] mem_addr,
	input wire logic mem_ack,
	input wire logic pend_valid,
	input wire logic [IVT_NUM_W-1:0] pend_num,
	input wire logic busy,
	input wire logic vec_valid,
	input wire ivt_vec_s vec,
	input wire logic [IVT_ADDR_W-1:0] vector_base_register
);
	logic [1:0] ack_cnt_q;
	logic [IVT_ADDR_W-1:0] exp_entry_q;
	logic [IVT_NUM_W-1:0] exp_num_q;

	// byte count and expected entry of the running fetch; base may be unaligned
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			ack_cnt_q <= 2'h0;
			exp_entry_q <= '0;
			exp_num_q <= '0;
		end
		else
		begin
			if (mem_req && mem_ack)
				ack_cnt_q <= ack_cnt_q + 2'h1;
			if (take_valid && !busy)
			begin
				exp_entry_q <= vector_base_register + IVT_ADDR_W'({take_num, 2'h0});
				exp_num_q <= take_num;
			end
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_take;
		take_valid && !busy;
	endsequence
	sequence s_ack_last;
		mem_req && mem_ack && ack_cnt_q == IVT_LAST_BYTE;
	endsequence
	a_fetch_addr: assert property (s_take |=> mem_req
		&& mem_addr == $past(vector_base_register) + {$past(take_num), 2'h0}) else $error("bad fetch address");
	a_byte_step: assert property (mem_req && mem_ack && ack_cnt_q != IVT_LAST_BYTE
		|=> mem_req && mem_addr == $past(mem_addr) + 20'h1) else $error("bad byte step");
	a_req_drop: assert property (s_ack_last |=> !mem_req) else $error("fetch too long");
	a_vec_time: assert property (s_ack_last |-> ##2 vec_valid) else $error("result late");
	a_entry_base: assert property (vec_valid
		|-> vec.entry_addr == exp_entry_q && vec.num == exp_num_q) else $error("bad entry");
	a_stack_sel: assert property (vec_valid |-> vec.force_isp == (vec.num < IVT_NUM_SW_LO))
		else $error("bad stack select");
	a_no_mask: assert property (vec_valid && (vec.num == 6'h0 || vec.num >= IVT_NUM_SW_LO)
		|-> vec.nonmaskable) else $error("maskable");
	a_pend_mask: assert property (!irq_enable |=> !pend_valid) else $error("pending while masked");
	a_no_reserved: assert property (pend_valid |-> !IVT_RESERVED[pend_num[4:0]] && pend_num != 6'h0)
		else $error("reserved number");
endmodule
bind ivt_vector ivt_vector_chk i_ivt_vector_chk (.sys_clk(sys_clk), .rstn(rstn), .irq_enable(irq_enable),
	.take_valid(take_valid), .take_num(take_num), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
	.pend_valid(pend_valid), .pend_num(pend_num), .busy(busy), .vec_valid(vec_valid), .vec(vec),
	.vector_base_register(vector_base_register));
`default_nettype wire

// *** test/ivt_mem_model.sv ***
// byte memory model returning vector table bytes computed from the address
`timescale 1ns/1ps
`default_nettype none
module ivt_mem_model
(
	// fetch port
	input wire logic sys_clk,
	input wire logic slow,
	input wire logic mem_req,
	input wire logic [19:0] mem_addr,
	output logic mem_ack,
	output logic [7:0] mem_rdata
);
	logic go_q = 1'b0;
	logic [7:0] junk_q = 8'h00;
	always @(posedge sys_clk)
	begin
		go_q <= slow ? ($urandom % 3 == 0) : 1'b1;
		junk_q <= junk_q + 8'h3B;
	end
	// every entry byte computed from its address, acknowledged when go_q is set
	assign mem_ack = mem_req && go_q;
	assign mem_rdata = mem_ack ? (mem_addr[7:0] ^ mem_addr[15:8] ^ 8'hA5) : junk_q;
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the variable vector table
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ivt_pkg::*;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic base_wr = 1'b0;
	logic irq_enable = 1'b0;
	logic take_valid = 1'b0;
	logic take_sw = 1'b0;
	logic slow = 1'b0;
	logic [19:0] base_data = 20'h0;
	logic [5:0] take_num = 6'h0;
	ivt_src_s srcs = '0;
	logic mem_req, mem_ack, pend_valid, busy, vec_valid;
	logic [19:0] mem_addr, base_q, vbr;
	logic [7:0] mem_rdata;
	logic [5:0] pend_num;
	logic [5:0] corner [5] = '{6'h00, 6'h04, 6'h1F, 6'h20, 6'h3F};
	ivt_vec_s vec;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;
	always #25 sys_clk = ~sys_clk;
	ivt_vector i_ivt_vector (.sys_clk(sys_clk), .rstn(rstn), .base_wr(base_wr), .base_data(base_data),
		.irq_enable(irq_enable), .srcs(srcs), .take_valid(take_valid), .take_sw(take_sw), .take_num(take_num),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.pend_valid(pend_valid), .pend_num(pend_num), .busy(busy), .vec_valid(vec_valid), .vec(vec),
		.vector_base_register(vbr));
	ivt_mem_model i_ivt_mem_model (.sys_clk(sys_clk), .slow(slow), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));
	function automatic logic [7:0] byte_at(logic [19:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction
	function automatic logic [5:0] exp_pend(ivt_src_s s);
		for (int i = 0; i < 24; i++)
			if (s[i])
				return (i == 0) ? 6'h04 : (i == 1) ? 6'h08 : 6'(i + 7);
		return 6'h00;
	endfunction
	task chk(input logic ok, input string what);
		num_checks++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task take(input logic [5:0] n, input logic sw);
		logic [19:0] e;
		logic [7:0] hi;
		e = base_q + {12'h0, n, 2'h0};
		hi = byte_at(e + 20'h2);
		take_num = n;
		take_sw = sw;
		take_valid = 1'b1;
		@(negedge sys_clk);
		chk(busy === 1'b1, "not busy");
		chk(mem_req === 1'b1 && mem_addr === e, "fetch start");
		// second take while busy must be ignored
		take_num = n ^ 6'h01;
		@(negedge sys_clk);
		take_valid = 1'b0;
		for (int k = 0; k < 60 && vec_valid !== 1'b1; k++)
			@(negedge sys_clk);
		chk(vec_valid === 1'b1, "no result");
		chk(busy === 1'b0 && mem_req === 1'b0, "still busy");
		chk(vec.entry_addr === e, "entry");
		chk(vec.handler === {hi[3:0], byte_at(e + 20'h1), byte_at(e)}, "handler");
		chk(vec.num === n, "number");
		chk(vec.nonmaskable === (sw || n == 6'h0 || n >= 6'h20), "mask");
		chk(vec.force_isp === (n < 6'h20), "stack");
	endtask
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			finish_test;
		end
	end
	initial
	begin
		void'($urandom(32'h50d65a3e));
		repeat (2) @(negedge sys_clk);
		rstn = 1'b1;
		for (int i = 0; i < 24; i++)
		begin
			if (i % 6 == 0)
			begin
				base_q = (i == 0) ? 20'hFFF00 : 20'($urandom % 32'hFFF00);
				base_data = base_q;
				base_wr = 1'b1;
				@(negedge sys_clk);
				base_wr = 1'b0;
				@(negedge sys_clk);
				chk(vbr === base_q, "base");
			end
			slow = i[0];
			take(i < 5 ? corner[i] : 6'($urandom), 1'($urandom));
		end
		for (int i = 0; i < 40; i++)
		begin
			srcs = (i < 24) ? 24'h1 << i : 24'($urandom);
			irq_enable = (i != 39);
			repeat (2) @(negedge sys_clk);
			chk(pend_valid === (srcs != '0 && irq_enable), "pending");
			if (pend_valid === 1'b1)
				chk(pend_num === exp_pend(srcs), "source number");
		end
		finish_test;
	end
endmodule
`default_nettype wire
